// ==== rtl/hrxf_map.svh ====
/*
  Register map, field positions, reset values and limits of the host
  receive FIFO datapath.
  Assumes inclusion by the datapath only.
*/
`ifndef HRXF_MAP_SVH
`define HRXF_MAP_SVH

// ***************************************************
// Register byte addresses
// ***************************************************
`define HRXF_A_DATA 8'h00
`define HRXF_A_STAT 8'h04
`define HRXF_A_INFO 8'h08
`define HRXF_A_CTRL 8'h0c
`define HRXF_A_CFG 8'h10
`define HRXF_A_ERR 8'h14

// ***************************************************
// Fields
// ***************************************************
`define HRXF_INF_DATA 15:0
`define HRXF_INF_STAT 23:16
`define HRXF_CTRL_SKIP 31
`define HRXF_CFG_OFS 4:0
`define HRXF_CFG_BURST 11:8
`define HRXF_CFG_PADEN 12
`define HRXF_CFG_DUMP 15
`define HRXF_CFG_RST 16'h0000
`define HRXF_ERR_RX 0

// ***************************************************
// Status word layout
// ***************************************************
`define HRXF_ST_FILT 30
`define HRXF_ST_LEN 29:16
`define HRXF_ST_ES 15
`define HRXF_ST_BCAST 13
`define HRXF_ST_LENERR 12
`define HRXF_ST_RUNT 11
`define HRXF_ST_MCAST 10
`define HRXF_ST_LONG 7
`define HRXF_ST_LATE 6
`define HRXF_ST_FTYPE 5
`define HRXF_ST_WDOG 4
`define HRXF_ST_MII 3
`define HRXF_ST_DRIB 2
`define HRXF_ST_CRC 1

// ***************************************************
// Frame limits
// ***************************************************
`define HRXF_RUNT_BYTES 14'd64
`define HRXF_MAX_BYTES 14'd1518
`define HRXF_LEN_MAX 14'h3fff

`endif

// ==== rtl/hrxf_pkg.sv ====
/*
  Types shared by the host receive FIFO datapath.
  Assumes the map header is available on the include path.
*/
package hrxf_pkg;

  // One byte from the host MAC interface layer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } hrxf_mil_byte_t;

  // Per-frame flags, valid together with the last byte
  typedef struct packed {
    logic filt_fail;
    logic bcast;
    logic mcast;
    logic len_err;
    logic frame_type;
    logic watchdog;
    logic mii_err;
    logic dribble;
    logic late_col;
    logic crc_err;
    logic rx_er;
  } hrxf_mil_stat_t;

  // Ingress sequencer, Gray along idle-offset-data-pad-status
  typedef enum logic [2:0] {
    HRXF_IDLE = 3'b000,
    HRXF_OFFS = 3'b001,
    HRXF_DATA = 3'b011,
    HRXF_PAD = 3'b010,
    HRXF_STAT = 3'b110
  } hrxf_state_t;

endpackage

// ==== rtl/hrxf_fifo.sv ====
/*
  Synchronous FIFO with clear and fill count.
  Assumes one clock; pop on empty and push on full are blocked.
*/
`timescale 1ns/1ps
module hrxf_fifo #(
  parameter int W = 33,
  parameter int AW = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic pop,
  output logic [W-1:0] head,
  output logic full,
  output logic empty,
  output logic [AW:0] count
);

  logic [W-1:0] mem [0:(1<<AW)-1];
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
  logic do_push, do_pop;

  // Pointers carry one extra bit so full and empty differ
  assign count = wr_reg - rd_reg;
  assign empty = (wr_reg == rd_reg);
  assign full = (count == (AW+1)'(1 << AW));
  assign head = mem[rd_reg[AW-1:0]];
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  // Next pointers; a clear overrides any traffic
  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    if (clr) begin
      wr_next = '0;
      rd_next = '0;
    end else begin
      if (do_push) wr_next = wr_reg + 1'b1;
      if (do_pop) rd_next = rd_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (do_push && !clr) begin
      mem[wr_reg[AW-1:0]] <= push_data;
    end
  end

endmodule

// ==== rtl/hrxf_datapath.sv ====
/*
  Host receive FIFO datapath: packs MAC bytes into a data FIFO with
  start offset and burst padding, queues one status word per frame,
  and serves both FIFOs and its control registers over Wishbone.
  Assumes one 50 MHz clock, a MAC that honours mil_ready_o, and a
  host that keeps its own side of the read discipline.
*/
// Notes on behaviour
// - Received bytes are packed into the data FIFO, pointer advancing per word.
// - After a frame's last data one status word goes to the status FIFO.
// - An info register shows queued data amount and status word count.
// - Status words may be popped before the matching data is read.
// - Underrun raises the receiver error flag; soft reset recovers sync.
// - Each frame's data starts after a programmable 0 to 31 byte offset.
// - With padding on, filler words follow each frame to fill bursts.
// - Offset and padding are applied to every frame separately.
// - Skip bit moves the data read pointer to the next frame, then clears.
// - Skip touches only the data FIFO; the status word stays queued.
// - Skip works while frames keep arriving.
// - Dump bit resets pointers of both FIFOs, then clears itself.
// - Status bit 31 zero, bit 30 filter fail, bits 29:16 length.
// - Status bit 15 is the OR of bits 11, 7, 6 and 1.
// - Status bit 13 flags broadcast; bit 14 reads zero.
// - Status bit 11 flags a frame shorter than 64 bytes.
// - Status bit 7 flags frames over 1518 bytes, not truncated.
// - Status bit 6 flags a late collision.
// - Status bit 1 flags CRC error or a receive error in the frame.
`timescale 1ns/1ps
`include "hrxf_map.svh"
module hrxf_datapath #(
  parameter int DATA_AW = 9,
  parameter int STAT_AW = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire hrxf_pkg::hrxf_mil_byte_t mil_byte_i,
  input wire hrxf_pkg::hrxf_mil_stat_t mil_stat_i,
  output logic mil_ready_o,
  output logic rx_error_flag_o
);

  // ***************************************************
  // Helpers
  // ***************************************************

  // Place a byte at its lane, little endian within the word
  function automatic logic [31:0] put_byte(input logic [31:0] acc,
      input logic [1:0] lane, input logic [7:0] b);
    put_byte = acc | ({24'h000000, b} << {lane, 3'b000});
  endfunction

  // Word position within a burst of (burst + 1) dwords
  function automatic logic [3:0] bump(input logic [3:0] pos,
      input logic [3:0] burst);
    bump = (pos == burst) ? 4'h0 : pos + 4'h1;
  endfunction

  // Build the status word from length and captured frame flags
  function automatic logic [31:0] stat_word(input logic [13:0] len,
      input hrxf_pkg::hrxf_mil_stat_t s);
    logic [31:0] w;
    w = 32'h00000000;
    w[`HRXF_ST_FILT] = s.filt_fail;
    w[`HRXF_ST_LEN] = len;
    w[`HRXF_ST_BCAST] = s.bcast;
    w[`HRXF_ST_LENERR] = s.len_err;
    w[`HRXF_ST_RUNT] = (len < `HRXF_RUNT_BYTES);
    w[`HRXF_ST_MCAST] = s.mcast;
    w[`HRXF_ST_LONG] = (len > `HRXF_MAX_BYTES);
    w[`HRXF_ST_LATE] = s.late_col;
    w[`HRXF_ST_FTYPE] = s.frame_type;
    w[`HRXF_ST_WDOG] = s.watchdog;
    w[`HRXF_ST_MII] = s.mii_err;
    w[`HRXF_ST_DRIB] = s.dribble;
    w[`HRXF_ST_CRC] = s.crc_err | s.rx_er;
    w[`HRXF_ST_ES] = w[`HRXF_ST_RUNT] | w[`HRXF_ST_LONG] |
        w[`HRXF_ST_LATE] | w[`HRXF_ST_CRC];
    stat_word = w;
  endfunction

  // ***************************************************
  // State
  // ***************************************************
  hrxf_pkg::hrxf_state_t st_reg, st_next;
  logic [1:0] lane_reg, lane_next;
  logic [31:0] acc_reg, acc_next;
  logic [4:0] ocnt_reg, ocnt_next;
  logic [13:0] len_reg, len_next;
  logic [3:0] bcnt_reg, bcnt_next;
  hrxf_pkg::hrxf_mil_stat_t info_reg, info_next;
  logic [15:0] cfg_reg, cfg_next;
  logic skip_reg, skip_next;
  logic err_reg, err_next;
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;

  // FIFO handshakes
  logic dpush, dpop, dfull, dempty;
  logic [32:0] dpush_data, dhead;
  logic [DATA_AW:0] dcount;
  logic spush, spop, sfull, sempty;
  logic [31:0] spush_data, shead;
  logic [STAT_AW:0] scount;
  logic clr;

  // Packing scratch
  logic byte_en, force_push, last_tag;
  logic [7:0] byte_val;
  logic [31:0] wacc;
  logic take;
  logic [3:0] burst;

  assign burst = cfg_reg[`HRXF_CFG_BURST];
  assign take = wb_cyc_i && wb_stb_i && !ack_reg;
  assign mil_ready_o = (st_reg == hrxf_pkg::HRXF_DATA) && !dfull;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign rx_error_flag_o = err_reg;

  // ***************************************************
  // FIFOs
  // ***************************************************
  hrxf_fifo #(.W(33), .AW(DATA_AW)) u_data (
    .clk(clk), .rst(rst), .clr(clr),
    .push(dpush), .push_data(dpush_data), .pop(dpop),
    .head(dhead), .full(dfull), .empty(dempty), .count(dcount)
  );

  hrxf_fifo #(.W(32), .AW(STAT_AW)) u_stat (
    .clk(clk), .rst(rst), .clr(clr),
    .push(spush), .push_data(spush_data), .pop(spop),
    .head(shead), .full(sfull), .empty(sempty), .count(scount)
  );

  // ***************************************************
  // Next-state logic: ingress, skip, dump and bus
  // ***************************************************

  // Bus writes are applied last so a set beats an internal clear
  always_comb begin
    st_next = st_reg;
    lane_next = lane_reg;
    acc_next = acc_reg;
    ocnt_next = ocnt_reg;
    len_next = len_reg;
    bcnt_next = bcnt_reg;
    info_next = info_reg;
    cfg_next = cfg_reg;
    skip_next = skip_reg;
    err_next = err_reg;
    ack_next = take;
    dat_next = dat_reg;
    dpush = 1'b0;
    dpush_data = 33'h000000000;
    dpop = 1'b0;
    spush = 1'b0;
    spush_data = 32'h00000000;
    spop = 1'b0;
    clr = soft_rst;
    byte_en = 1'b0;
    byte_val = 8'h00;
    force_push = 1'b0;
    last_tag = 1'b0;
    wacc = 32'h00000000;

    // Ingress sequencer; every frame restarts offset and pad
    case (st_reg)
      hrxf_pkg::HRXF_IDLE: begin
        if (mil_byte_i.valid) begin
          lane_next = 2'h0;
          acc_next = 32'h00000000;
          len_next = 14'h0000;
          bcnt_next = 4'h0;
          ocnt_next = cfg_reg[`HRXF_CFG_OFS];
          st_next = (cfg_reg[`HRXF_CFG_OFS] != 5'h00) ?
              hrxf_pkg::HRXF_OFFS : hrxf_pkg::HRXF_DATA;
        end
      end
      hrxf_pkg::HRXF_OFFS: begin
        if (!dfull) begin
          byte_en = 1'b1;
          ocnt_next = ocnt_reg - 5'h01;
          if (ocnt_reg == 5'h01) st_next = hrxf_pkg::HRXF_DATA;
        end
      end
      hrxf_pkg::HRXF_DATA: begin
        if (mil_byte_i.valid && !dfull) begin
          byte_en = 1'b1;
          byte_val = mil_byte_i.data;
          if (len_reg != `HRXF_LEN_MAX) len_next = len_reg + 14'h0001;
          if (mil_byte_i.last) begin
            force_push = 1'b1;
            info_next = mil_stat_i;
            // No pad when disabled or the burst is already whole
            last_tag = !cfg_reg[`HRXF_CFG_PADEN] ||
                (bump(bcnt_reg, burst) == 4'h0);
            st_next = last_tag ? hrxf_pkg::HRXF_STAT : hrxf_pkg::HRXF_PAD;
          end
        end
      end
      hrxf_pkg::HRXF_PAD: begin
        if (!dfull) begin
          force_push = 1'b1;
          last_tag = (bump(bcnt_reg, burst) == 4'h0);
          if (last_tag) st_next = hrxf_pkg::HRXF_STAT;
        end
      end
      hrxf_pkg::HRXF_STAT: begin
        // A full status FIFO drops the word and flags overrun
        if (sfull) begin
          err_next = 1'b1;
        end else begin
          spush = 1'b1;
          spush_data = stat_word(len_reg, info_reg);
        end
        st_next = hrxf_pkg::HRXF_IDLE;
      end
      default: st_next = hrxf_pkg::HRXF_IDLE;
    endcase

    // Shared packer: one byte per cycle, word pushed when complete
    if (byte_en || force_push) begin
      wacc = byte_en ? put_byte(acc_reg, lane_reg, byte_val) : acc_reg;
      if (lane_reg == 2'h3 || force_push) begin
        dpush = 1'b1;
        dpush_data = {last_tag, wacc};
        acc_next = 32'h00000000;
        lane_next = 2'h0;
        bcnt_next = bump(bcnt_reg, burst);
      end else begin
        acc_next = wacc;
        lane_next = lane_reg + 2'h1;
      end
    end

    // Skip drains data words up to the frame's tagged last word
    if (skip_reg && !dempty) begin
      dpop = 1'b1;
      if (dhead[32]) skip_next = 1'b0;
    end

    // Dump empties both FIFOs and restarts the ingress
    if (cfg_reg[`HRXF_CFG_DUMP]) begin
      clr = 1'b1;
      cfg_next[`HRXF_CFG_DUMP] = 1'b0;
      st_next = hrxf_pkg::HRXF_IDLE;
      skip_next = 1'b0;
    end

    // Wishbone request, answered on the next edge
    if (take) begin
      dat_next = 32'h00000000;
      if (!wb_we_i) begin
        case (wb_adr_i)
          `HRXF_A_DATA: begin
            if (dempty) err_next = 1'b1;
            else if (!skip_reg) begin
              dpop = 1'b1;
              dat_next = dhead[31:0];
            end
          end
          `HRXF_A_STAT: begin
            if (sempty) err_next = 1'b1;
            else begin
              spop = 1'b1;
              dat_next = shead;
            end
          end
          `HRXF_A_INFO: begin
            dat_next[`HRXF_INF_DATA] =
                16'({dcount, 2'b00});
            dat_next[`HRXF_INF_STAT] = 8'(scount);
          end
          `HRXF_A_CTRL: dat_next[`HRXF_CTRL_SKIP] = skip_reg;
          `HRXF_A_CFG: dat_next[15:0] = cfg_reg;
          `HRXF_A_ERR: dat_next[`HRXF_ERR_RX] = err_reg;
          default: dat_next = 32'h00000000;
        endcase
      end else begin
        case (wb_adr_i)
          `HRXF_A_CTRL: begin
            if (wb_sel_i[3] && wb_dat_i[`HRXF_CTRL_SKIP]) skip_next = 1'b1;
          end
          `HRXF_A_CFG: begin
            if (wb_sel_i[0]) cfg_next[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1]) cfg_next[15:8] = wb_dat_i[15:8];
          end
          `HRXF_A_ERR: begin
            // Write one clears, but a status overrun this cycle wins
            if (wb_sel_i[0] && wb_dat_i[`HRXF_ERR_RX])
              err_next = (st_reg == hrxf_pkg::HRXF_STAT) && sfull;
          end
          default: ;
        endcase
      end
    end
  end

  // ***************************************************
  // Registers
  // ***************************************************

  // Soft reset returns control state and FIFOs to their reset values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= hrxf_pkg::HRXF_IDLE;
      lane_reg <= 2'h0;
      acc_reg <= 32'h00000000;
      ocnt_reg <= 5'h00;
      len_reg <= 14'h0000;
      bcnt_reg <= 4'h0;
      info_reg <= '0;
      cfg_reg <= `HRXF_CFG_RST;
      skip_reg <= 1'b0;
      err_reg <= 1'b0;
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else if (soft_rst) begin
      st_reg <= hrxf_pkg::HRXF_IDLE;
      lane_reg <= 2'h0;
      acc_reg <= 32'h00000000;
      ocnt_reg <= 5'h00;
      len_reg <= 14'h0000;
      bcnt_reg <= 4'h0;
      info_reg <= '0;
      cfg_reg <= `HRXF_CFG_RST;
      skip_reg <= 1'b0;
      err_reg <= 1'b0;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end else begin
      st_reg <= st_next;
      lane_reg <= lane_next;
      acc_reg <= acc_next;
      ocnt_reg <= ocnt_next;
      len_reg <= len_next;
      bcnt_reg <= bcnt_next;
      info_reg <= info_next;
      cfg_reg <= cfg_next;
      skip_reg <= skip_next;
      err_reg <= err_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

endmodule

// ==== verification/hrxf_datapath_asserts.sv ====
/*
  Port assertions for the host receive FIFO datapath.
  Assumes a bind from the bench top file; sees the ports only.
*/
`timescale 1ns/1ps
module hrxf_datapath_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire hrxf_pkg::hrxf_mil_byte_t mil_byte_i,
  input wire hrxf_pkg::hrxf_mil_stat_t mil_stat_i,
  input wire logic mil_ready_o,
  input wire logic rx_error_flag_o
);
  // ****************************************
  // Bus, status word and flag checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic take;
  logic rd_stat;
  logic err_clr;
  // Taken request, status pop and flag clear, decoded from the bus
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_stat = take && !wb_we_i && wb_adr_i == 8'h04;
  assign err_clr = take && wb_we_i && wb_adr_i == 8'h14 && wb_sel_i[0]
    && wb_dat_i[0];
  property p_ack_next;
    take |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack long");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(take);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack alone");
  // Pad or status cycle, then one more cycle without ready, follow the last byte of a frame
  property p_stat_gap;
    mil_byte_i.valid && mil_byte_i.last && mil_ready_o |=> !mil_ready_o [*2];
  endproperty
  a_stat_gap: assert property (p_stat_gap)
    else $error("no gap");
  // Every write-one clear and every soft reset cycle is exempt from the hold
  property p_flag_hold;
    rx_error_flag_o && !err_clr && !soft_rst |=> rx_error_flag_o;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag lost");
  property p_soft;
    soft_rst |=> !rx_error_flag_o && !mil_ready_o;
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset");
  property p_stat_zero;
    rd_stat |=> wb_ack_o && wb_dat_o[31] == 1'b0 && wb_dat_o[14] == 1'b0;
  endproperty
  a_stat_zero: assert property (p_stat_zero)
    else $error("bits 31 14");
  property p_es_or;
    rd_stat |=> wb_dat_o[15] ==
      (wb_dat_o[11] | wb_dat_o[7] | wb_dat_o[6] | wb_dat_o[1]);
  endproperty
  a_es_or: assert property (p_es_or)
    else $error("summary bit");
  property p_len_flags;
    rd_stat ##1 wb_dat_o[29:16] != 14'h0000 |->
      wb_dat_o[11] == (wb_dat_o[29:16] < 14'h0040) &&
      wb_dat_o[7] == (wb_dat_o[29:16] > 14'h05ee);
  endproperty
  a_len_flags: assert property (p_len_flags)
    else $error("length bits");
endmodule

// ==== verification/hrxf_mac_model.sv ====
/*
  Behavioural MAC-side byte source feeding the receive datapath.
  Assumes send is called just after a rising clock edge.
*/
`timescale 1ns/1ps
module hrxf_mac_model (
  input wire logic clk,
  input wire logic mil_ready_o,
  output hrxf_pkg::hrxf_mil_byte_t mil_byte,
  output hrxf_pkg::hrxf_mil_stat_t mil_stat
);
  // ****************************************
  // Frame source
  // ****************************************
  // Lines start idle and low
  initial begin
    mil_byte = 10'h000;
    mil_stat = 11'h000;
  end
  // Bytes back to back; one moves on only when the datapath takes it
  task automatic send(input logic [13:0] len,
    input hrxf_pkg::hrxf_mil_stat_t st, input logic [7:0] seed);
    logic [13:0] k;
    k = 14'h0000;
    while (k < len) begin
      mil_byte.valid <= 1'b1;
      mil_byte.data <= seed + k[7:0];
      mil_byte.last <= k == len - 14'h0001;
      mil_stat <= (k == len - 14'h0001) ? st : ~st; // Wrong until last
      @(posedge clk);
      if (mil_ready_o === 1'b1)
        k = k + 14'h0001;
    end
    // Released data shows the inverse so a stale byte cannot match
    mil_byte.valid <= 1'b0;
    mil_byte.data <= ~mil_byte.data;
    mil_byte.last <= 1'b0;
    // One idle cycle, so a following frame never overwrites this step
    @(posedge clk);
  endtask
endmodule

// ==== verification/tb_host_rx_fifo_datapath.sv ====
/*
  Self-checking bench for the host receive FIFO datapath.
  Assumes the package, map header, FIFO and datapath compile first.
*/
`timescale 1ns/1ps
module tb_host_rx_fifo_datapath;
  logic clk, rst, soft_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rng, q;
  logic mil_ready_o, rx_error_flag_o;
  hrxf_pkg::hrxf_mil_byte_t mil_byte_i;
  hrxf_pkg::hrxf_mil_stat_t mil_stat_i;
  logic [13:0] lens[5] = '{14'h0001, 14'h003f, 14'h0040, 14'h05ee, 14'h05ef};
  int errors, cmp_count;
  // ****************************************
  // Harness, bus tasks and expectations
  // ****************************************
  hrxf_datapath u_hrxf_datapath (.clk(clk), .rst(rst), .soft_rst(soft_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mil_byte_i(mil_byte_i),
    .mil_stat_i(mil_stat_i), .mil_ready_o(mil_ready_o),
    .rx_error_flag_o(rx_error_flag_o));
  hrxf_mac_model u_hrxf_mac_model (.clk(clk), .mil_ready_o(mil_ready_o),
    .mil_byte(mil_byte_i), .mil_stat(mil_stat_i));
  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Flag is looked at two falling edges later, once the ack edge landed
  task automatic chk_flag(input logic exp);
    repeat (2) @(negedge clk);
    chk({31'h0, rx_error_flag_o}, {31'h0, exp});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Classic cycle held until ack is seen high at a rising edge
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20)
      errors++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0000_0000, 4'hf, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    logic [31:0] r;
    wb(1'b1, a, d, s, r);
  endtask
  // Poll the level register until n status words are queued
  task automatic wait_stat(input logic [7:0] n);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int k = 0; k < 300 && r[23:16] !== n; k++)
      rd(8'h08, r);
  endtask
  function automatic int nwords(int len, int off, logic pad, int bst);
    int w;
    w = (off + len + 3) / 4;
    if (pad)
      w = ((w + bst) / (bst + 1)) * (bst + 1);
    return w;
  endfunction
  function automatic logic [31:0] exp_stat(logic [13:0] len,
    hrxf_pkg::hrxf_mil_stat_t s);
    logic [31:0] w;
    w = {1'b0, s.filt_fail, len, 2'h0, s.bcast, s.len_err, len < 14'h0040,
      s.mcast, 2'h0, len > 14'h05ee, s.late_col, s.frame_type, s.watchdog,
      s.mii_err, s.dribble, s.crc_err | s.rx_er, 1'b0};
    w[15] = w[11] | w[7] | w[6] | w[1];
    return w;
  endfunction
  // Offset lanes are masked; tail and filler words must be zero
  task automatic chk_frame(input int len, input int off, input int nw,
    input logic [7:0] seed);
    logic [31:0] e, m, r;
    int n;
    for (int i = 0; i < nw; i++) begin
      e = 32'h0000_0000;
      m = 32'h0000_0000;
      for (int j = 0; j < 4; j++) begin
        n = 4 * i + j - off;
        m[8*j +: 8] = (n >= 0) ? 8'hff : 8'h00;
        e[8*j +: 8] = (n >= 0 && n < len) ? seed + n[7:0] : 8'h00;
      end
      rd(8'h00, r);
      chk(r & m, e);
    end
  endtask
  // Two frames under one random setting; statuses popped first
  task automatic run_pair(input int la, input int lb);
    int ln[2], nw[2], off, bst;
    logic pad;
    logic [7:0] sd[2];
    hrxf_pkg::hrxf_mil_stat_t st[2];
    logic [31:0] r, e;
    r = rnd();
    off = r[4:0];
    bst = r[11:8];
    pad = r[12];
    ln[0] = la;
    ln[1] = lb;
    wr(8'h10, {19'h0, pad, r[11:8], 3'h0, r[4:0]}, 4'h3);
    for (int f = 0; f < 2; f++) begin
      r = rnd();
      sd[f] = r[7:0];
      st[f] = r[18:8];
      nw[f] = nwords(ln[f], off, pad, bst);
      repeat (r[25:24]) @(posedge clk);
      u_hrxf_mac_model.send(14'(ln[f]), st[f], sd[f]);
    end
    wait_stat(8'h02);
    rd(8'h08, r);
    chk(r, {16'h0002, 16'(4 * (nw[0] + nw[1]))});
    for (int f = 0; f < 2; f++) begin
      rd(8'h04, r);
      e = exp_stat(14'(ln[f]), st[f]);
      chk(r & 32'hffff_0000, e & 32'hffff_0000);
      chk(r[15:0], e[15:0]);
    end
    for (int f = 0; f < 2; f++)
      chk_frame(ln[f], off, nw[f], sd[f]);
    chk_flag(1'b0);
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {rst, soft_rst, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h10;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
    rng = 32'h130e7a99;
    errors = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wr(8'h18, 32'hffff_ffff, 4'hf);
    for (int a = 8; a <= 24; a += 4) begin
      rd(a[7:0], q);
      chk(q, 32'h0000_0000);
    end
    $display("test reset_values done");
    for (int i = 0; i < 10; i++) begin
      q = rnd();
      run_pair(i < 5 ? lens[i] : 1 + q % 200, 1 + q[15:8] % 100);
    end
    $display("test offset_padding done");
    // Skip the head frame while a third one is still arriving
    wr(8'h10, 32'h0000_0000, 4'h3);
    u_hrxf_mac_model.send(14'h0028, 11'h001, 8'h10);
    u_hrxf_mac_model.send(14'h0017, 11'h400, 8'h50);
    wait_stat(8'h02);
    fork
      u_hrxf_mac_model.send(14'h001e, 11'h000, 8'h90);
      begin
        wr(8'h0c, 32'h8000_0000, 4'h8);
        q = 32'h8000_0000;
        for (int k = 0; k < 100 && q[31]; k++)
          rd(8'h0c, q);
      end
    join
    chk(q & 32'h8000_0000, 32'h0000_0000);
    wait_stat(8'h03);
    rd(8'h04, q);
    chk(q, exp_stat(14'h0028, 11'h001));
    rd(8'h04, q);
    rd(8'h04, q);
    chk_frame(23, 0, 6, 8'h50);
    chk_frame(30, 0, 8, 8'h90);
    rd(8'h08, q);
    chk(q, 32'h0000_0000);
    $display("test skip done");
    // Underrun on purpose: flag clears by write one, then by soft reset
    rd(8'h04, q);
    chk(q, 32'h0000_0000);
    chk_flag(1'b1);
    rd(8'h14, q);
    chk(q, 32'h0000_0001);
    wr(8'h14, 32'h0000_0001, 4'h1);
    chk_flag(1'b0);
    rd(8'h00, q);
    chk_flag(1'b1);
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    chk_flag(1'b0);
    $display("test underrun done");
    // Dump with the source idle empties both FIFOs
    u_hrxf_mac_model.send(14'h0020, 11'h000, 8'h33);
    wait_stat(8'h01);
    wr(8'h10, 32'h0000_8000, 4'h2);
    rd(8'h10, q);
    chk(q & 32'h0000_8000, 32'h0000_0000);
    rd(8'h08, q);
    chk(q, 32'h0000_0000);
    $display("test dump done");
    print_verdict();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #2000000;
    errors++;
    print_verdict();
  end
endmodule
bind hrxf_datapath hrxf_datapath_asserts u_hrxf_datapath_asserts (
  .clk(clk), .rst(rst), .soft_rst(soft_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .mil_byte_i(mil_byte_i), .mil_stat_i(mil_stat_i),
  .mil_ready_o(mil_ready_o), .rx_error_flag_o(rx_error_flag_o));
